/* pulse_next_pkg.sv */
// constants, register indices and carrier types for the pulse next-value block
// assumes a 32-bit apb bus with word-aligned registers
package pulse_next_pkg;

  localparam int          ADDR_W        = 22;
  localparam int          DATA_W        = 32;
  localparam int          NUM_GROUPS    = 4;
  localparam int          NUM_CHANNELS  = 3;

  // register indices; byte address is four times the index
  localparam logic [19:0] IDX_NEXT_HIGH = 20'hFFFA4;
  localparam logic [19:0] IDX_NEXT_LOW  = 20'hFFFA5;
  localparam logic [19:0] IDX_GRP2_ALT  = 20'hFFFA6;
  localparam logic [19:0] IDX_GRP0_ALT  = 20'hFFFA7;
  localparam logic [19:0] IDX_ENA_LOW   = 20'hFFFB0;
  localparam logic [19:0] IDX_ENA_HIGH  = 20'hFFFB1;
  localparam logic [19:0] IDX_TRIG_SEL  = 20'hFFFB2;
  localparam logic [19:0] IDX_PORT_A    = 20'hFFFB3;
  localparam logic [19:0] IDX_PORT_B    = 20'hFFFB4;
  localparam logic [19:0] IDX_CONTROL   = 20'hFFFB5;

  // reset values
  localparam logic [7:0]  RST_NEXT      = 8'h00;
  localparam logic [7:0]  RST_ENABLE    = 8'h00;
  localparam logic [7:0]  RST_TRIG_SEL  = 8'hFF;
  localparam logic [7:0]  RST_PORT      = 8'h00;
  localparam logic        RST_ACTIVE    = 1'b0;

  // field positions
  localparam int          NIB_HI_MSB    = 7;
  localparam int          NIB_HI_LSB    = 4;
  localparam int          NIB_LO_MSB    = 3;
  localparam int          NIB_LO_LSB    = 0;
  localparam int          SEL_W         = 2;
  localparam int          CTRL_ACTIVE   = 0;

  localparam logic [3:0]  NIB_ONES      = 4'hF;
  localparam logic [7:0]  BYTE_ONES     = 8'hFF;

  // trigger channel codes
  localparam logic [1:0]  CHAN_0        = 2'h0;
  localparam logic [1:0]  CHAN_1        = 2'h1;
  localparam logic [1:0]  CHAN_2        = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              err;
  } apb_rsp_t;

endpackage

/* pulse_group_trigger.sv */
// decodes one group's trigger-select field into a channel and a fire strobe
// assumes compare-match strobes are one-cycle pulses on the same clock
`timescale 1ns/100ps
module pulse_group_trigger (
  input  wire logic [1:0] sel,
  input  wire logic [2:0] cmp_match,
  input  wire logic       active,
  output logic      [1:0] chan,
  output logic            fire
);

  always_comb begin
    if (sel[1]) begin
      chan = pulse_next_pkg::CHAN_2;
    end else if (sel[0]) begin
      chan = pulse_next_pkg::CHAN_1;
    end else begin
      chan = pulse_next_pkg::CHAN_0;
    end
    fire = active & cmp_match[chan];
  end

endmodule

/* pulse_next_data.sv */
// next-value holding registers and timed pulse port output transfer
// assumes an apb master on clk and compare-match pulses from on-chip timers
//
// How it works
// RL1: an 8-bit read/write register holds the next values for groups 1 and 0.
// RL2: while active, a selected compare match copies low-pair bits to port A.
// RL3: reset and hardware standby clear the low-pair register, else it holds.
// RL4: one trigger for groups 0 and 1 puts the whole byte at one index.
// RL5: with that shared trigger the companion index reads ones, no writes.
// RL6: separate triggers: group 1 at the first index, group 0 at the other.
// RL7: separate triggers: unused nibble at each index reads ones, locked.
// RL8: an 8-bit read/write register holds next values for groups 3 and 2.
// RL9: while active, selected compare match copies high-pair bits to port B.
// RL10: reset and hardware standby clear the high-pair register, else holds.
// RL11: one trigger for groups 2 and 3: byte at one index, other all ones.
// RL12: separate triggers split groups 3 and 2, unused nibbles read ones.
// RL13: a bit moves to the port only when its enable bit is set.
// RL14: sharing compares the decoded trigger channels each cycle.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module pulse_next_data (
  input  wire logic                               clk,
  input  wire logic                               nrst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [pulse_next_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pulse_next_pkg::DATA_W-1:0]  pwdata,
  output logic      [pulse_next_pkg::DATA_W-1:0]  prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [2:0]                         cmp_match,
  input  wire logic                               hw_standby,
  output logic      [7:0]                         port_a_output_data,
  output logic      [7:0]                         port_b_output_data
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  pulse_next_pkg::apb_req_t req;
  pulse_next_pkg::apb_rsp_t rsp;
  logic [7:0] next_value_low_pair_q;
  logic [7:0] next_value_high_pair_q;
  logic [7:0] next_value_enable_low_q;
  logic [7:0] next_value_enable_high_q;
  logic [7:0] pulse_trigger_select_q;
  logic [7:0] port_a_q;
  logic [7:0] port_b_q;
  logic       active_q;
  logic       standby_meta_q;
  logic       standby_q;
  logic       pready_q;
  logic [pulse_next_pkg::DATA_W-1:0] prdata_q;
  logic       pslverr_q;
  logic [1:0] chan [pulse_next_pkg::NUM_GROUPS];
  logic [pulse_next_pkg::NUM_GROUPS-1:0] fire;
  logic [7:0] fire_a;
  logic [7:0] fire_b;
  logic       shared_low;
  logic       shared_high;
  logic       acc_start;
  logic       wr_en;

  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  function automatic logic hit(input logic [pulse_next_pkg::ADDR_W-1:0] a,
                               input logic [19:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // hardware standby synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      standby_meta_q <= 1'b0;
      standby_q      <= 1'b0;
    end else begin
      standby_meta_q <= hw_standby;
      standby_q      <= standby_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger decode per group
  generate
    for (genvar g = 0; g < pulse_next_pkg::NUM_GROUPS; g++) begin : g_grp
      pulse_group_trigger u_trig (
        .sel       (pulse_trigger_select_q[2*g+1:2*g]),
        .cmp_match (cmp_match),
        .active    (active_q),
        .chan      (chan[g]),
        .fire      (fire[g])
      );
    end
  endgenerate

  assign shared_low  = (chan[0] == chan[1]); // RL14
  assign shared_high = (chan[2] == chan[3]); // RL14
  assign fire_a = {{4{fire[1]}}, {4{fire[0]}}};
  assign fire_b = {{4{fire[3]}}, {4{fire[2]}}};

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, write lands on the pready edge
  assign acc_start = psel & penable & ~pready_q;
  assign wr_en     = psel & penable & pready_q & req.write;

  always_comb begin
    rsp.rdata = '0;
    rsp.err   = 1'b0;
    if (hit(req.addr, pulse_next_pkg::IDX_NEXT_LOW)) begin
      if (shared_low) begin
        rsp.rdata[7:0] = next_value_low_pair_q; // RL4
      end else begin
        rsp.rdata[7:0] = {next_value_low_pair_q[7:4],
                          pulse_next_pkg::NIB_ONES}; // RL7
      end
    end else if (hit(req.addr, pulse_next_pkg::IDX_GRP0_ALT)) begin
      if (shared_low) begin
        rsp.rdata[7:0] = pulse_next_pkg::BYTE_ONES; // RL5
      end else begin
        rsp.rdata[7:0] = {pulse_next_pkg::NIB_ONES,
                          next_value_low_pair_q[3:0]}; // RL6
      end
    end else if (hit(req.addr, pulse_next_pkg::IDX_NEXT_HIGH)) begin
      if (shared_high) begin
        rsp.rdata[7:0] = next_value_high_pair_q; // RL11
      end else begin
        rsp.rdata[7:0] = {next_value_high_pair_q[7:4],
                          pulse_next_pkg::NIB_ONES}; // RL12
      end
    end else if (hit(req.addr, pulse_next_pkg::IDX_GRP2_ALT)) begin
      if (shared_high) begin
        rsp.rdata[7:0] = pulse_next_pkg::BYTE_ONES; // RL11
      end else begin
        rsp.rdata[7:0] = {pulse_next_pkg::NIB_ONES,
                          next_value_high_pair_q[3:0]}; // RL12
      end
    end else if (hit(req.addr, pulse_next_pkg::IDX_ENA_LOW)) begin
      rsp.rdata[7:0] = next_value_enable_low_q;
    end else if (hit(req.addr, pulse_next_pkg::IDX_ENA_HIGH)) begin
      rsp.rdata[7:0] = next_value_enable_high_q;
    end else if (hit(req.addr, pulse_next_pkg::IDX_TRIG_SEL)) begin
      rsp.rdata[7:0] = pulse_trigger_select_q;
    end else if (hit(req.addr, pulse_next_pkg::IDX_PORT_A)) begin
      rsp.rdata[7:0] = port_a_q;
    end else if (hit(req.addr, pulse_next_pkg::IDX_PORT_B)) begin
      rsp.rdata[7:0] = port_b_q;
    end else if (hit(req.addr, pulse_next_pkg::IDX_CONTROL)) begin
      rsp.rdata[pulse_next_pkg::CTRL_ACTIVE] = active_q;
    end else begin
      rsp.err = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc_start;
      if (acc_start) begin
        prdata_q  <= req.write ? '0 : rsp.rdata;
        pslverr_q <= rsp.err;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-value registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      next_value_low_pair_q <= pulse_next_pkg::RST_NEXT; // RL3
    end else if (standby_q) begin
      next_value_low_pair_q <= pulse_next_pkg::RST_NEXT; // RL3
    end else if (wr_en) begin
      if (hit(req.addr, pulse_next_pkg::IDX_NEXT_LOW)) begin
        if (shared_low) begin
          next_value_low_pair_q <= req.wdata[7:0]; // RL1
        end else begin
          next_value_low_pair_q[7:4] <= req.wdata[7:4]; // RL6
        end
      end else if (hit(req.addr, pulse_next_pkg::IDX_GRP0_ALT) &&
                   !shared_low) begin
        next_value_low_pair_q[3:0] <= req.wdata[3:0]; // RL6
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      next_value_high_pair_q <= pulse_next_pkg::RST_NEXT; // RL10
    end else if (standby_q) begin
      next_value_high_pair_q <= pulse_next_pkg::RST_NEXT; // RL10
    end else if (wr_en) begin
      if (hit(req.addr, pulse_next_pkg::IDX_NEXT_HIGH)) begin
        if (shared_high) begin
          next_value_high_pair_q <= req.wdata[7:0]; // RL8
        end else begin
          next_value_high_pair_q[7:4] <= req.wdata[7:4]; // RL12
        end
      end else if (hit(req.addr, pulse_next_pkg::IDX_GRP2_ALT) &&
                   !shared_high) begin
        next_value_high_pair_q[3:0] <= req.wdata[3:0]; // RL12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables, trigger select and control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      next_value_enable_low_q  <= pulse_next_pkg::RST_ENABLE;
      next_value_enable_high_q <= pulse_next_pkg::RST_ENABLE;
      pulse_trigger_select_q   <= pulse_next_pkg::RST_TRIG_SEL;
      active_q                 <= pulse_next_pkg::RST_ACTIVE;
    end else if (standby_q) begin
      next_value_enable_low_q  <= pulse_next_pkg::RST_ENABLE;
      next_value_enable_high_q <= pulse_next_pkg::RST_ENABLE;
      pulse_trigger_select_q   <= pulse_next_pkg::RST_TRIG_SEL;
      active_q                 <= pulse_next_pkg::RST_ACTIVE;
    end else if (wr_en) begin
      if (hit(req.addr, pulse_next_pkg::IDX_ENA_LOW)) begin
        next_value_enable_low_q <= req.wdata[7:0];
      end else if (hit(req.addr, pulse_next_pkg::IDX_ENA_HIGH)) begin
        next_value_enable_high_q <= req.wdata[7:0];
      end else if (hit(req.addr, pulse_next_pkg::IDX_TRIG_SEL)) begin
        pulse_trigger_select_q <= req.wdata[7:0];
      end else if (hit(req.addr, pulse_next_pkg::IDX_CONTROL)) begin
        active_q <= req.wdata[pulse_next_pkg::CTRL_ACTIVE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port output data: enabled bits follow transfers and are write-locked
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_a_q <= pulse_next_pkg::RST_PORT;
    end else if (standby_q) begin
      port_a_q <= pulse_next_pkg::RST_PORT;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (next_value_enable_low_q[b]) begin
          if (fire_a[b]) begin
            port_a_q[b] <= next_value_low_pair_q[b]; // RL2
          end
        end else if (wr_en && hit(req.addr, pulse_next_pkg::IDX_PORT_A)) begin
          port_a_q[b] <= req.wdata[b]; // RL13
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_q <= pulse_next_pkg::RST_PORT;
    end else if (standby_q) begin
      port_b_q <= pulse_next_pkg::RST_PORT;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (next_value_enable_high_q[b]) begin
          if (fire_b[b]) begin
            port_b_q[b] <= next_value_high_pair_q[b]; // RL9
          end
        end else if (wr_en && hit(req.addr, pulse_next_pkg::IDX_PORT_B)) begin
          port_b_q[b] <= req.wdata[b]; // RL13
        end
      end
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign port_a_output_data = port_a_q;
  assign port_b_output_data = port_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_standby_clear;
    @(posedge clk) disable iff (!nrst)
    standby_q |=> (next_value_low_pair_q == 8'h00) &&
                  (next_value_high_pair_q == 8'h00);
  endproperty
  a_standby_clear: assert property (p_standby_clear) // RL3
    else $error("next-value registers not cleared in standby");
  property p_transfer_a;
    @(posedge clk) disable iff (!nrst)
    (fire[0] && next_value_enable_low_q[0] && !standby_q)
      |=> port_a_q[0] == $past(next_value_low_pair_q[0]);
  endproperty
  a_transfer_a: assert property (p_transfer_a) // RL2
    else $error("port a bit not loaded on compare match");
  property p_transfer_b;
    @(posedge clk) disable iff (!nrst)
    (fire[3] && next_value_enable_high_q[7] && !standby_q)
      |=> port_b_q[7] == $past(next_value_high_pair_q[7]);
  endproperty
  a_transfer_b: assert property (p_transfer_b) // RL9
    else $error("port b bit not loaded on compare match");
  property p_disabled_hold;
    @(posedge clk) disable iff (!nrst)
    (!next_value_enable_low_q[7] && !wr_en && !standby_q)
      |=> $stable(port_a_q[7]);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) // RL13
    else $error("disabled port bit changed");
  property p_alias_ones;
    @(posedge clk) disable iff (!nrst)
    (acc_start && !req.write && shared_low &&
     hit(req.addr, pulse_next_pkg::IDX_GRP0_ALT))
      |=> pready_q && prdata_q == 32'h0000_00FF;
  endproperty
  a_alias_ones: assert property (p_alias_ones) // RL5
    else $error("shared companion index not all ones");
  property p_split_read;
    @(posedge clk) disable iff (!nrst)
    (acc_start && !req.write && !shared_low &&
     hit(req.addr, pulse_next_pkg::IDX_NEXT_LOW))
      |=> prdata_q[3:0] == 4'hF &&
          prdata_q[7:4] == $past(next_value_low_pair_q[7:4]);
  endproperty
  a_split_read: assert property (p_split_read) // RL7
    else $error("separate-trigger first index read wrong");
  property p_shared_write;
    @(posedge clk) disable iff (!nrst)
    (wr_en && shared_low && !standby_q &&
     hit(req.addr, pulse_next_pkg::IDX_NEXT_LOW))
      |=> next_value_low_pair_q == $past(req.wdata[7:0]);
  endproperty
  a_shared_write: assert property (p_shared_write) // RL4
    else $error("shared write did not land whole byte");
  property p_alias_locked;
    @(posedge clk) disable iff (!nrst)
    (wr_en && shared_high && !standby_q &&
     hit(req.addr, pulse_next_pkg::IDX_GRP2_ALT))
      |=> $stable(next_value_high_pair_q);
  endproperty
  a_alias_locked: assert property (p_alias_locked) // RL11
    else $error("write to shared companion changed register");
  property p_split_write;
    @(posedge clk) disable iff (!nrst)
    (wr_en && !shared_high && !standby_q &&
     hit(req.addr, pulse_next_pkg::IDX_NEXT_HIGH))
      |=> next_value_high_pair_q[3:0] == $past(next_value_high_pair_q[3:0]);
  endproperty
  a_split_write: assert property (p_split_write) // RL12
    else $error("locked nibble written");
  property p_share_decode;
    @(posedge clk) disable iff (!nrst)
    (pulse_trigger_select_q[1:0] == 2'h3 &&
     pulse_trigger_select_q[3:2] == 2'h2) |-> shared_low;
  endproperty
  a_share_decode: assert property (p_share_decode) // RL14
    else $error("equal channels not seen as shared");
  c_transfer: cover property (@(posedge clk) disable iff (!nrst)
    fire[0] && next_value_enable_low_q[0]);
  c_split_write: cover property (@(posedge clk) disable iff (!nrst)
    wr_en && !shared_low && hit(req.addr, pulse_next_pkg::IDX_GRP0_ALT));
  c_unmapped: cover property (@(posedge clk) disable iff (!nrst)
    pready_q && pslverr_q);

endmodule

/* timer_match_model.sv */
// compare-match event source for three on-chip timer channels
// assumes one clock shared with the block under test
`timescale 1ns/100ps
module timer_match_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  output logic      [2:0] cmp_match
);
  ////////////////////////////////////////////////////////////////////////////
  // quiet at time zero and while reset is held
  initial begin
    cmp_match = 3'h0;
  end

  always @(negedge nrst) begin
    cmp_match <= 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse on the chosen channels, launched after a rising edge
  task automatic pulse(input logic [2:0] chans);
    @(posedge clk);
    cmp_match <= chans;
    @(posedge clk);
    cmp_match <= 3'h0;
  endtask
endmodule

/* pulse_next_data_test.sv */
// self-checking bench for the pulse next-value registers
// assumes an apb slave and three timer compare-match lines on one clock
`timescale 1ns/100ps
module pulse_next_data_test;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [21:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  cmp_match;
  logic        hw_standby;
  logic [7:0]  port_a;
  logic [7:0]  port_b;
  logic [31:0] rd_v;
  logic        er_v;
  int          miscompares;
  int          total_checks;
  int          cycles;

  ////////////////////////////////////////////////////////////////////////////
  pulse_next_data dut (
    .clk                (clk),
    .nrst               (nrst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .cmp_match          (cmp_match),
    .hw_standby         (hw_standby),
    .port_a_output_data (port_a),
    .port_b_output_data (port_b)
  );

  timer_match_model u_tmr (
    .clk       (clk),
    .nrst      (nrst),
    .cmp_match (cmp_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // setup cycle, access phase until pready, then release
  task automatic apb(input logic wr, input logic [19:0] idx,
                     input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input string nm, input logic [19:0] idx,
                     input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd_v, {24'h000000, exp});
  endtask

  task automatic fire(input logic [2:0] ch);
    u_tmr.pulse(ch);
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 22'h000000;
    pwdata = 32'h00000000;
    hw_standby = 1'b0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // reset state, shared triggers
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'h00);
    rdc("high", pulse_next_pkg::IDX_NEXT_HIGH, 8'h00);
    rdc("alt0", pulse_next_pkg::IDX_GRP0_ALT, 8'hFF);
    rdc("alt2", pulse_next_pkg::IDX_GRP2_ALT, 8'hFF);
    // whole bytes, companion writes ignored
    wr(pulse_next_pkg::IDX_NEXT_LOW, 8'hA5);
    wr(pulse_next_pkg::IDX_NEXT_HIGH, 8'h3C);
    wr(pulse_next_pkg::IDX_GRP0_ALT, 8'h00);
    wr(pulse_next_pkg::IDX_GRP2_ALT, 8'h00);
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'hA5);
    rdc("alt0", pulse_next_pkg::IDX_GRP0_ALT, 8'hFF);
    rdc("high", pulse_next_pkg::IDX_NEXT_HIGH, 8'h3C);
    rdc("alt2", pulse_next_pkg::IDX_GRP2_ALT, 8'hFF);
    // transfer on channel 2 with partial enables
    wr(pulse_next_pkg::IDX_ENA_LOW, 8'hFF);
    wr(pulse_next_pkg::IDX_ENA_HIGH, 8'h0F);
    wr(pulse_next_pkg::IDX_CONTROL, 8'h01);
    fire(3'h4);
    chk("port_a", {24'h0, port_a}, 32'h000000A5);
    chk("port_b", {24'h0, port_b}, 32'h0000000C);
    // inactive output holds the port
    wr(pulse_next_pkg::IDX_NEXT_LOW, 8'h5A);
    wr(pulse_next_pkg::IDX_CONTROL, 8'h00);
    fire(3'h4);
    chk("port_a", {24'h0, port_a}, 32'h000000A5);
    wr(pulse_next_pkg::IDX_CONTROL, 8'h01);
    // separate triggers: g0 ch0, g1 ch1, g2 ch0, g3 ch2
    wr(pulse_next_pkg::IDX_TRIG_SEL, 8'h84);
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'h5F);
    rdc("alt0", pulse_next_pkg::IDX_GRP0_ALT, 8'hFA);
    rdc("high", pulse_next_pkg::IDX_NEXT_HIGH, 8'h3F);
    rdc("alt2", pulse_next_pkg::IDX_GRP2_ALT, 8'hFC);
    wr(pulse_next_pkg::IDX_NEXT_LOW, 8'h30);
    wr(pulse_next_pkg::IDX_GRP0_ALT, 8'h09);
    wr(pulse_next_pkg::IDX_GRP2_ALT, 8'h07);
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'h3F);
    rdc("alt0", pulse_next_pkg::IDX_GRP0_ALT, 8'hF9);
    fire(3'h1);
    chk("port_a", {24'h0, port_a}, 32'h000000A9);
    chk("port_b", {24'h0, port_b}, 32'h00000007);
    fire(3'h2);
    chk("port_a", {24'h0, port_a}, 32'h00000039);
    fire(3'h4);
    chk("port_b", {24'h0, port_b}, 32'h00000007);
    // back to shared decode: codes 10 and 11 both pick channel 2
    wr(pulse_next_pkg::IDX_TRIG_SEL, 8'hEB);
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'h39);
    rdc("high", pulse_next_pkg::IDX_NEXT_HIGH, 8'h37);
    // unmapped index
    apb(1'b0, 20'h00010, 8'h00);
    chk("err", {31'h0, er_v}, 32'h00000001);
    chk("rdata", rd_v, 32'h00000000);
    // hardware standby clears
    @(posedge clk);
    hw_standby <= 1'b1;
    repeat (4) @(posedge clk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge clk);
    rdc("low", pulse_next_pkg::IDX_NEXT_LOW, 8'h00);
    rdc("high", pulse_next_pkg::IDX_NEXT_HIGH, 8'h00);
    chk("port_a", {24'h0, port_a}, 32'h00000000);
    report_and_stop();
  end
endmodule
